// *** self_program_defines.svh ***
`ifndef SELF_PROGRAM_DEFINES_SVH
`define SELF_PROGRAM_DEFINES_SVH

// ==========================================================
// Register offsets on the Wishbone bus.
`define OFS_CONTROL_STATUS 4'h0
`define OFS_LOCK_FUSE_VIEW 4'h4

// ==========================================================
// Control and status bit positions.
`define BIT_READY_IE 7
`define BIT_SECTION_BUSY 6
`define BIT_RESERVED 5
`define BIT_REENABLE 4
`define BIT_LOCK_SET 3
`define BIT_PAGE_WRITE 2
`define BIT_PAGE_ERASE 1
`define BIT_STORE_EN 0

// Legal low five bit patterns.
`define PAT_REENABLE 5'h11
`define PAT_LOCK_SET 5'h09
`define PAT_PAGE_WRITE 5'h05
`define PAT_PAGE_ERASE 5'h03
`define PAT_BUFFER_LOAD 5'h01

// ==========================================================
// Reset values and timing.
`define RST_CONTROL_STATUS 8'h00
`define RST_LOCK_BITS 8'hff
`define LOCK_KEEP_MASK 8'hc3
`define ERASED_WORD 16'hffff
`define STORE_WINDOW 3'h4
`define LOAD_WINDOW 3'h3
`define CLK_MHZ 10
`define T_ERASE_US 4000
`define T_WRITE_US 4000

`endif

// *** self_program_pkg.sv ***
package self_program_pkg;

  // One instruction request from the processor core.
  typedef struct packed {
    logic store;        // One-cycle store-program instruction strobe.
    logic load;         // One-cycle load-program instruction strobe.
    logic extension;    // Pointer page extension bit.
    logic [15:0] ptr;   // Pointer value.
    logic [7:0] r1;     // High data byte.
    logic [7:0] r0;     // Low data byte.
  } core_req_t;

  // Sequencer states, one-hot.
  typedef enum logic [3:0] {
    st_idle  = 4'b0001,
    st_armed = 4'b0010,
    st_erase = 4'b0100,
    st_write = 4'b1000
  } seq_state_t;

endpackage

// *** self_program_flash_control.sv ***
// The implementer's own choices: register access over Wishbone and the register offsets.
`include "self_program_defines.svh"

// How it works
// [RQ1] Reset vector follows the boot reset fuse.
// [RQ2] Fuses are read-only to the processor.
// [RQ3] Ready interrupt requested while store-enable is clear.
// [RQ4] Section erase or write sets busy, blocks section.
// [RQ5] Starting a buffer load clears busy.
// [RQ6] Re-enable with store clears busy after programming.
// [RQ7] Re-enable ignored while erase or write runs.
// [RQ8] Re-enable write aborts load, drops buffered data.
// [RQ9] Reserved bit five always reads zero.
// [RQ10] Lock-set store programs boot lock bits from R0.
// [RQ11] Lock-set clears on completion or window timeout.
// [RQ12] Load within three cycles returns lock or fuses.
// [RQ13] Page write stores buffer to pointer page.
// [RQ14] Page erase clears pointer page, data ignored.
// [RQ15] Stalling-section programming halts the processor.
// [RQ16] Plain store puts R1:R0 into buffer word.
// [RQ17] Store-enable lasts four cycles, held while programming.
// [RQ18] Only five low bit patterns have effect.
// [RQ19] Flash page latched when programming begins.
// [RQ20] Word address splits into page and word.
// [RQ21] Byte reads use the pointer low bit.
// [RQ22] Software erases then writes the same page.
// [RQ23] Buffer clears after write, re-enable, reset.
// [RQ24] Locked application section refuses stores.
// [RQ25] Erase and write durations are parameters.
module self_program_flash_control #(
  parameter int WORD_BITS = 7,
  parameter int PAGE_BITS = 10,
  parameter logic [9:0] BOOT_START_PAGE = 10'h3e0,
  parameter int ERASE_CYCLES = `T_ERASE_US * `CLK_MHZ,
  parameter int WRITE_CYCLES = `T_WRITE_US * `CLK_MHZ
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire self_program_pkg::core_req_t core_req,
  input wire logic global_irq_enable,
  input wire logic boot_reset_fuse,
  input wire logic [7:0] fuse_low,
  input wire logic [7:0] fuse_high,
  input wire logic [7:0] fuse_ext,
  input wire logic [WORD_BITS-1:0] flash_buf_addr,
  output logic [15:0] flash_buf_data,
  output logic [PAGE_BITS-1:0] flash_page,
  output logic flash_erase_start,
  output logic flash_write_start,
  output logic [7:0] load_data,
  output logic load_valid,
  output logic cpu_stall,
  output logic section_busy_flag,
  output logic ready_irq,
  output logic [PAGE_BITS+WORD_BITS-1:0] reset_vector
);

  localparam int WORDS = 1 << WORD_BITS;

  // ==========================================================
  // State and storage.
  self_program_pkg::seq_state_t state;  // Sequencer state.
  logic [4:0] cmd;                      // Accepted low control bits.
  logic ready_interrupt_enable;         // Bit seven of control.
  logic [2:0] window;                   // Cycles left for a store.
  logic [2:0] load_window;              // Cycles left for a load.
  logic [31:0] op_count;                // Programming duration count.
  logic [7:0] lock_bits;                // Boot lock bits.
  logic [15:0] page_buffer [WORDS];     // Temporary page buffer.
  logic [WORDS-1:0] word_valid;         // Buffer words loaded.
  logic stalling_op;                    // Operation is in stall area.

  // ==========================================================
  // Decode of the pointer and of bus accesses.
  logic store_enable;
  logic [PAGE_BITS+WORD_BITS-1:0] word_addr;
  logic [WORD_BITS-1:0] word_in_page_bits;
  logic [PAGE_BITS-1:0] page_index_bits;
  logic pointer_lsb;
  logic bus_write;
  logic ctrl_write;
  logic [4:0] wr_pat;
  logic legal_pat;
  logic page_locked;
  logic [7:0] control_view;

  // The word address drops the pointer byte bit.
  assign word_addr = {core_req.extension, core_req.ptr[15:1]};
  assign word_in_page_bits = word_addr[WORD_BITS-1:0]; // see [RQ20]
  assign page_index_bits = word_addr[PAGE_BITS+WORD_BITS-1:WORD_BITS];
  assign pointer_lsb = core_req.ptr[0];
  assign store_enable = (state != self_program_pkg::st_idle);
  // A write acts at the edge where the master still holds it and sees ack.
  assign bus_write = wb_cyc_i & wb_stb_i & wb_we_i & wb_ack_o;
  assign ctrl_write = bus_write & wb_sel_i[0] &
                      (wb_adr_i == `OFS_CONTROL_STATUS);
  assign wr_pat = wb_dat_i[4:0];

  // Only the five documented patterns count as commands.
  always_comb begin
    unique case (wr_pat)
      `PAT_REENABLE, `PAT_LOCK_SET, `PAT_PAGE_WRITE,
      `PAT_PAGE_ERASE, `PAT_BUFFER_LOAD: legal_pat = 1'b1; // see [RQ18]
      default: legal_pat = 1'b0;
    endcase
  end

  // Application pages refuse stores when bit BLB01 is programmed,
  // and boot pages when BLB11 is programmed.
  always_comb begin
    if (page_index_bits < BOOT_START_PAGE) begin
      page_locked = ~lock_bits[2]; // see [RQ24]
    end else begin
      page_locked = ~lock_bits[4];
    end
  end

  // Reserved bit five is held at zero in the read view.
  assign control_view = {ready_interrupt_enable, section_busy_flag,
                         1'b0, cmd[4:1], store_enable}; // see [RQ9]

  // ==========================================================
  // Reset vector, caught by the clocked reset.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      if (boot_reset_fuse) begin
        reset_vector <= '0; // see [RQ1]
      end else begin
        reset_vector <= {BOOT_START_PAGE, {WORD_BITS{1'b0}}};
      end
    end
  end

  // ==========================================================
  // Wishbone slave: one wait-free answer a cycle after the request.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
      unique case (wb_adr_i)
        `OFS_CONTROL_STATUS: wb_dat_o <= {24'h0, control_view};
        // Fuses only appear here; nothing writes them.
        `OFS_LOCK_FUSE_VIEW: wb_dat_o <= {fuse_ext, fuse_high,
                                          fuse_low, lock_bits}; // see [RQ2]
        default: wb_dat_o <= '0;
      endcase
    end
  end

  // ==========================================================
  // Interrupt enable bit, written at any time.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_interrupt_enable <= 1'b0;
    end else if (ctrl_write) begin
      ready_interrupt_enable <= wb_dat_i[`BIT_READY_IE];
    end
  end

  // Ready request is a level while store-enable reads zero.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ready_irq <= 1'b0;
    end else begin
      ready_irq <= ready_interrupt_enable & global_irq_enable &
                   ~store_enable; // see [RQ3]
    end
  end

  // ==========================================================
  // Command sequencer.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= self_program_pkg::st_idle;
      cmd <= 5'h00;
      window <= 3'h0;
      load_window <= 3'h0;
      op_count <= '0;
      flash_page <= '0;
      stalling_op <= 1'b0;
    end else begin
      unique case (state)
        // A legal pattern arms the store window; writes while
        // programming never reach here, so re-enable is ignored then.
        self_program_pkg::st_idle: begin
          if (ctrl_write && legal_pat) begin // see [RQ7]
            state <= self_program_pkg::st_armed;
            cmd <= wr_pat;
            window <= `STORE_WINDOW; // see [RQ17]
            load_window <= `LOAD_WINDOW;
          end
        end
        // The window runs out unless a store or a lock-set load ends it.
        self_program_pkg::st_armed: begin
          window <= window - 3'h1;
          if (load_window != 3'h0) begin
            load_window <= load_window - 3'h1;
          end
          if (core_req.store) begin
            if (cmd == `PAT_PAGE_ERASE && !page_locked) begin
              state <= self_program_pkg::st_erase; // see [RQ14]
              flash_page <= page_index_bits; // see [RQ19]
              stalling_op <= (page_index_bits >= BOOT_START_PAGE);
              op_count <= 32'(ERASE_CYCLES - 1); // see [RQ25]
            end else if (cmd == `PAT_PAGE_WRITE && !page_locked) begin
              state <= self_program_pkg::st_write; // see [RQ13]
              flash_page <= page_index_bits;
              stalling_op <= (page_index_bits >= BOOT_START_PAGE);
              op_count <= 32'(WRITE_CYCLES - 1);
            end else begin
              state <= self_program_pkg::st_idle; // see [RQ11]
              cmd <= 5'h00;
            end
          end else if (core_req.load && cmd == `PAT_LOCK_SET &&
                       load_window != 3'h0) begin
            state <= self_program_pkg::st_idle;
            cmd <= 5'h00;
          end else if (window == 3'h1) begin
            state <= self_program_pkg::st_idle; // see [RQ11]
            cmd <= 5'h00;
          end
        end
        // Store-enable stays set until the duration ends.
        self_program_pkg::st_erase, self_program_pkg::st_write: begin
          op_count <= op_count - 32'h1;
          if (op_count == 32'h0) begin
            state <= self_program_pkg::st_idle; // see [RQ17]
            cmd <= 5'h00;
            stalling_op <= 1'b0;
          end
        end
      endcase
    end
  end

  // One-cycle starts toward the flash array.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_erase_start <= 1'b0;
      flash_write_start <= 1'b0;
    end else begin
      flash_erase_start <= (state == self_program_pkg::st_armed) &
                           core_req.store & ~page_locked &
                           (cmd == `PAT_PAGE_ERASE);
      flash_write_start <= (state == self_program_pkg::st_armed) &
                           core_req.store & ~page_locked &
                           (cmd == `PAT_PAGE_WRITE);
    end
  end

  // The processor halts while programming the stalling area.
  assign cpu_stall = stalling_op; // see [RQ15]

  // ==========================================================
  // Section busy flag; set wins over any clear in the same cycle.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      section_busy_flag <= 1'b0;
    end else if ((flash_erase_start || flash_write_start) &&
                 !stalling_op) begin
      // A stalling-area operation leaves the flag as it was.
      section_busy_flag <= 1'b1; // see [RQ4]
    end else if (state == self_program_pkg::st_armed &&
                 core_req.store &&
                 (cmd == `PAT_BUFFER_LOAD ||
                  cmd == `PAT_REENABLE)) begin
      section_busy_flag <= 1'b0; // see [RQ5] see [RQ6]
    end
  end

  // ==========================================================
  // Boot lock bits can only be programmed, taken from R0.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      lock_bits <= `RST_LOCK_BITS;
    end else if (state == self_program_pkg::st_armed &&
                 core_req.store && cmd == `PAT_LOCK_SET) begin
      lock_bits <= lock_bits & (core_req.r0 | `LOCK_KEEP_MASK); // see [RQ10]
    end
  end

  // Lock or fuse readback; the pointer low bits pick the byte.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      load_data <= 8'h00;
      load_valid <= 1'b0;
    end else begin
      load_valid <= 1'b0;
      if (state == self_program_pkg::st_armed && core_req.load &&
          cmd == `PAT_LOCK_SET && load_window != 3'h0) begin
        load_valid <= 1'b1; // see [RQ12]
        unique case ({core_req.ptr[1], pointer_lsb}) // see [RQ21]
          2'b00: load_data <= fuse_low;
          2'b01: load_data <= lock_bits;
          2'b10: load_data <= fuse_ext;
          2'b11: load_data <= fuse_high;
        endcase
      end
    end
  end

  // ==========================================================
  // Page buffer valid bits, cleared by reset, page write end and
  // any accepted re-enable write (which aborts a load in progress).
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      word_valid <= '0; // see [RQ23]
    end else if ((state == self_program_pkg::st_write &&
                  op_count == 32'h0) ||
                 (ctrl_write && wr_pat == `PAT_REENABLE &&
                  !store_enable)) begin
      word_valid <= '0; // see [RQ8] see [RQ23]
    end else if (state == self_program_pkg::st_armed &&
                 core_req.store && cmd == `PAT_BUFFER_LOAD) begin
      word_valid[word_in_page_bits] <= 1'b1;
    end
  end

  // Buffer words, one generate entry each.
  for (genvar i = 0; i < WORDS; i++) begin : g_word
    always_ff @(posedge ref_clk) begin
      if (state == self_program_pkg::st_armed && core_req.store &&
          cmd == `PAT_BUFFER_LOAD &&
          word_in_page_bits == WORD_BITS'(i)) begin
        page_buffer[i] <= {core_req.r1, core_req.r0}; // see [RQ16]
      end
    end
  end

  // Flash side read port; unloaded words read as erased.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      flash_buf_data <= `ERASED_WORD;
    end else if (word_valid[flash_buf_addr]) begin
      flash_buf_data <= page_buffer[flash_buf_addr];
    end else begin
      flash_buf_data <= `ERASED_WORD;
    end
  end

endmodule

// *** flash_ctl_checker.sv ***
// ==========================================================
// Port checker for the self-programming flash control.
module flash_ctl_checker #(
  parameter int WORD_BITS = 7,
  parameter int PAGE_BITS = 10,
  parameter logic [9:0] BOOT_START_PAGE = 10'h3e0
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic global_irq_enable,
  input wire logic [PAGE_BITS-1:0] flash_page,
  input wire logic flash_erase_start,
  input wire logic flash_write_start,
  input wire logic load_valid,
  input wire logic cpu_stall,
  input wire logic section_busy_flag,
  input wire logic ready_irq,
  input wire logic [PAGE_BITS+WORD_BITS-1:0] reset_vector
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // A bus request that has not yet been answered.
  sequence s_req;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  // A flash operation being launched.
  sequence s_start;
    flash_erase_start || flash_write_start;
  endsequence
  a_ack_answer: assert property (s_req |=> wb_ack_o)
    else $error("bus request not answered in one cycle");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("acknowledge longer than one cycle");
  a_reserved_zero: assert property (
    wb_ack_o && !wb_we_i && wb_adr_i == 4'h0 |-> wb_dat_o[5] == 1'b0)
    else $error("reserved control bit read as one");
  a_start_pulse: assert property (
    s_start |=> !flash_erase_start && !flash_write_start)
    else $error("flash start longer than one cycle");
  a_busy_on_start: assert property (
    flash_erase_start && flash_page < BOOT_START_PAGE
    |-> ##[0:1] section_busy_flag)
    else $error("section busy not raised by erase");
  a_stall_page: assert property (
    cpu_stall && $past(cpu_stall) |-> flash_page >= BOOT_START_PAGE)
    else $error("stall for a page outside the stalling section");
  a_irq_gated: assert property (
    !$past(global_irq_enable) |-> !ready_irq)
    else $error("ready interrupt without global enable");
  a_irq_busy: assert property (s_start |-> ##1 !ready_irq [*3])
    else $error("ready interrupt while programming");
  a_load_pulse: assert property (load_valid |=> !load_valid)
    else $error("load valid longer than one cycle");
  a_vector_hold: assert property (
    !$past(rst) |-> $stable(reset_vector))
    else $error("reset vector changed outside reset");
endmodule

bind self_program_flash_control flash_ctl_checker #(
  .WORD_BITS(WORD_BITS),
  .PAGE_BITS(PAGE_BITS),
  .BOOT_START_PAGE(BOOT_START_PAGE)
) chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .global_irq_enable, .flash_page,
  .flash_erase_start, .flash_write_start, .load_valid, .cpu_stall,
  .section_busy_flag, .ready_irq, .reset_vector);

// *** core_model.sv ***
// ==========================================================
// Processor core issuing store and load program instructions.
module core_model (
  input wire logic ref_clk,
  input wire logic cpu_stall,
  input wire logic load_valid,
  input wire logic [7:0] load_data,
  output self_program_pkg::core_req_t core_req
);
  timeunit 1ns;
  timeprecision 1ns;
  initial core_req = '0;
  // One instruction: st high for store, low for load.
  // Afterwards pointer and data show a changed pattern.
  task automatic op(input logic st, input logic [16:0] a,
    input logic [15:0] d, output logic [8:0] got);
    // A halted core issues nothing until released, waiting at most 99 cycles.
    for (int i = 0; i < 99 && cpu_stall === 1'b1; i++) begin
      @(posedge ref_clk);
    end
    core_req <= {st, !st, a, d};
    @(posedge ref_clk);
    core_req <= {2'b00, ~a, ~d};
    @(posedge ref_clk);
    got = {load_valid, load_data};
  endtask
endmodule

// *** tb_self_program_flash_control.sv ***
// ==========================================================
// Self-checking bench for the self-programming flash control.
module tb_self_program_flash_control;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [9:0] BSP = 10'h1f0;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic gie = 1'b1;
  logic bfuse = 1'b0;
  logic [3:0] sel = 4'h1;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat, rd;
  logic [6:0] baddr = 7'h0;
  logic [15:0] bdata;
  logic [9:0] page;
  logic [7:0] ldat;
  logic [16:0] vec;
  logic [8:0] got;
  logic [7:0] pat [4] = '{8'h01, 8'h09, 8'h03, 8'h05};
  logic [7:0] fz [4] = '{8'he1, 8'hfb, 8'hfd, 8'h99};
  logic ack, lval, stall, busy, irq, es, ws;
  self_program_pkg::core_req_t req;
  int error_cnt = 0;
  int n_checks = 0;
  always #50 ref_clk = ~ref_clk;
  core_model core (.ref_clk, .cpu_stall(stall), .load_valid(lval),
    .load_data(ldat), .core_req(req));
  self_program_flash_control #(.BOOT_START_PAGE(BSP), .ERASE_CYCLES(20),
    .WRITE_CYCLES(20)) dut (.ref_clk, .rst, .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .core_req(req),
    .global_irq_enable(gie), .boot_reset_fuse(bfuse), .fuse_low(8'he1),
    .fuse_high(8'h99), .fuse_ext(8'hfd), .flash_buf_addr(baddr),
    .flash_buf_data(bdata), .flash_page(page), .flash_erase_start(es),
    .flash_write_start(ws), .load_data(ldat), .load_valid(lval),
    .cpu_stall(stall), .section_busy_flag(busy), .ready_irq(irq),
    .reset_vector(vec));
  // ==========================================================
  // Shared tasks.
  task automatic check(input string what, input logic [31:0] s, e);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("unexpected %s exp %h seen %h", what, e, s);
    end
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // One classic Wishbone cycle; read data lands in rd.
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge ref_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= {24'h0, d};
    i = 0;
    do begin
      @(posedge ref_clk);
      i++;
    end while (ack !== 1'b1 && i < 20);
    if (ack !== 1'b1) begin
      error_cnt++;
      final_report();
    end
    rd = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic rd_chk(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 8'h00);
    check("register", rd, e);
  endtask
  // Polls the control register until store-enable drops.
  task automatic wait_idle();
    for (int i = 0; i < 30; i++) begin
      bus(1'b0, 4'h0, 8'h00);
      if (rd[0] === 1'b0) break;
    end
    check("store enable", rd[0], 1'b0);
    if (rd[0] !== 1'b0) begin
      final_report();
    end
  endtask
  task automatic buf_chk(input logic [15:0] e);
    baddr <= 7'h3;
    repeat (2) @(posedge ref_clk);
    check("buffer", bdata, e);
  endtask
  // ==========================================================
  // Main sequence.
  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    check("vector", vec, {BSP, 7'h0});
    rd_chk(4'h0, 32'h0);
    bus(1'b1, 4'h4, 8'h00);
    rd_chk(4'h4, 32'hfd99e1ff);
    bus(1'b1, 4'h8, 8'h55);
    rd_chk(4'h8, 32'h0);
    // Illegal low patterns keep only the enable bit.
    foreach (pat[k]) begin
      bus(1'b1, 4'h0, 8'h80 | (pat[k] ^ 8'h0e));
      rd_chk(4'h0, 32'h80);
    end
    // A write without its byte lane changes nothing.
    sel <= 4'h0;
    bus(1'b1, 4'h0, 8'h01);
    sel <= 4'h1;
    rd_chk(4'h0, 32'h80);
    check("irq", irq, 1'b1);
    gie <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check("irq", irq, 1'b0);
    gie <= 1'b1;
    // Buffer load, lock set, erase and write each lapse when no store follows.
    foreach (pat[k]) begin
      bus(1'b1, 4'h0, pat[k]);
      repeat (6) @(posedge ref_clk);
      rd_chk(4'h0, 32'h0);
    end
    bus(1'b1, 4'h0, 8'h01);
    core.op(1'b1, 17'h00507, 16'h1234, got);
    buf_chk(16'h1234);
    // Erase then write the same page.
    bus(1'b1, 4'h0, 8'h03);
    core.op(1'b1, 17'h00500, 16'h0000, got);
    check("start", {es, ws}, 2'b10);
    rd_chk(4'h0, 32'h43);
    check("page", page, 10'h005);
    bus(1'b1, 4'h0, 8'h11);
    rd_chk(4'h0, 32'h43);
    wait_idle();
    rd_chk(4'h0, 32'h40);
    bus(1'b1, 4'h0, 8'h05);
    core.op(1'b1, 17'h00500, 16'h0000, got);
    check("start", {es, ws}, 2'b01);
    wait_idle();
    buf_chk(16'hffff);
    bus(1'b1, 4'h0, 8'h11);
    core.op(1'b1, 17'h00500, 16'h0000, got);
    rd_chk(4'h0, 32'h0);
    // A buffer load clears busy; a re-enable drops the load.
    bus(1'b1, 4'h0, 8'h03);
    core.op(1'b1, 17'h00500, 16'h0000, got);
    wait_idle();
    bus(1'b1, 4'h0, 8'h01);
    core.op(1'b1, 17'h00506, 16'h5a5a, got);
    rd_chk(4'h0, 32'h0);
    bus(1'b1, 4'h0, 8'h11);
    buf_chk(16'hffff);
    // Erase in the stalling section with the ready request enabled.
    bus(1'b1, 4'h0, 8'h83);
    core.op(1'b1, 17'h1f000, 16'h0000, got);
    @(posedge ref_clk);
    check("stall", {stall, busy, irq}, 3'b100);
    wait_idle();
    check("stall", stall, 1'b0);
    check("irq", irq, 1'b1);
    // Lock bits program from R0 and read back with fuses.
    bus(1'b1, 4'h0, 8'h09);
    core.op(1'b1, 17'h1ffff, 16'hfffb, got);
    rd_chk(4'h4, 32'hfd99e1fb);
    // The locked application area refuses an erase.
    bus(1'b1, 4'h0, 8'h03);
    core.op(1'b1, 17'h00500, 16'h0000, got);
    check("start", {es, ws}, 2'b00);
    rd_chk(4'h0, 32'h0);
    foreach (fz[k]) begin
      bus(1'b1, 4'h0, 8'h09);
      core.op(1'b0, 17'(k), 16'h0000, got);
      check("load", got, {1'b1, fz[k]});
    end
    // A second reset drops the buffer and the locks, and takes the fuse.
    bus(1'b1, 4'h0, 8'h01);
    core.op(1'b1, 17'h00506, 16'hbeef, got);
    buf_chk(16'hbeef);
    bfuse <= 1'b1;
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    check("vector", vec, 32'h0);
    buf_chk(16'hffff);
    rd_chk(4'h4, 32'hfd99e1ff);
    final_report();
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
endmodule
